// [frct_timer.v]
// Free-running capture/compare timer with byte register port
`timescale 1ns/1ps
`include "frct_defines.vh"
module frct_timer #(
  parameter PRESCALE_W = 5
) (
  input  wire       CLK,
  input  wire       RST_N,
  input  wire [3:0] ADDR,
  input  wire [7:0] WDATA,
  input  wire       WR,
  input  wire       RD,
  output reg  [7:0] RDATA,
  input  wire       LOW_POWER,
  input  wire       EXT_CLK,
  input  wire [3:0] CAPTURE_IN,
  output reg        COMPARE_OUT_A,
  output reg        COMPARE_OUT_A_OE,
  output reg        COMPARE_OUT_B,
  output reg        COMPARE_OUT_B_OE,
  output reg        IRQ
);

  // ==========================================================
  // State
  reg  [PRESCALE_W-1:0] prescale;
  reg                   sel_prev;
  reg  [15:0]           free_running_count;
  reg  [15:0]           compare_reg_a;
  reg  [15:0]           compare_reg_b;
  reg  [15:0]           capture_reg [0:3];
  reg  [7:0]            staging;
  reg  [7:0]            timer_control_reg;
  reg  [4:0]            compare_output_control;
  reg  [3:0]            capture_flag;
  reg                   compare_flag_a;
  reg                   compare_flag_b;
  reg                   overflow_flag;
  reg                   clear_on_match_a;
  reg  [6:0]            irq_enable_reg;

  // ==========================================================
  // Decoded fields
  wire [1:0] clock_select    = timer_control_reg[1:0];
  wire       buffer_enable_a = timer_control_reg[`FRCT_CTRL_BUF_A];
  wire       buffer_enable_b = timer_control_reg[`FRCT_CTRL_BUF_B];
  wire [3:0] capture_edge    = timer_control_reg[7:4];
  wire       cmp_sel         = compare_output_control[`FRCT_OC_SEL];
  wire       output_level_a  = compare_output_control[`FRCT_OC_LVL_A];
  wire       output_level_b  = compare_output_control[`FRCT_OC_LVL_B];

  // Port strobes for the contention cases
  wire wr_cnt_lo = WR & (ADDR == `FRCT_A_CNT_LO);
  wire wr_cmp_lo = WR & (ADDR == `FRCT_A_CMP_LO);
  wire wr_cmp_a  = wr_cmp_lo & ~cmp_sel;
  wire wr_cmp_b  = wr_cmp_lo & cmp_sel;
  wire wr_ctrl   = WR & (ADDR == `FRCT_A_CTRL);
  wire wr_octrl  = WR & (ADDR == `FRCT_A_OCTRL);
  wire wr_stat   = WR & (ADDR == `FRCT_A_STAT);
  wire wr_ien    = WR & (ADDR == `FRCT_A_IEN);

  // ==========================================================
  // Counter clock source
  reg sel_now;
  always @* begin
    case (clock_select)
      `FRCT_CKS_DIV2:  sel_now = prescale[`FRCT_TAP_DIV2];
      `FRCT_CKS_DIV8:  sel_now = prescale[`FRCT_TAP_DIV8];
      `FRCT_CKS_DIV32: sel_now = prescale[`FRCT_TAP_DIV32];
      // inverted so rising external edge reads as falling
      `FRCT_CKS_EXT:   sel_now = ~EXT_CLK;
      default:         sel_now = 1'b0;
    endcase
  end

  // source switches seen as edges too
  // A glitch-free switch would cost a handshake; the stray count is kept
  wire tick = sel_prev & ~sel_now;

  // ==========================================================
  // Compare, clear and overflow
  wire eq_a = (free_running_count == compare_reg_a);
  wire eq_b = (free_running_count == compare_reg_b);
  // strobe when counter leaves matching value
  wire match_a = tick & eq_a & ~wr_cmp_a;
  wire match_b = tick & eq_b & ~wr_cmp_b;
  wire cnt_clear = match_a & clear_on_match_a;
  wire ovf_set = tick & (free_running_count == `FRCT_CNT_MAX) & ~cnt_clear & ~wr_cnt_lo;

  // Counter next value
  reg [15:0] next_count;
  always @* begin
    if (cnt_clear) begin
      next_count = `FRCT_CNT_RST;
    end else if (wr_cnt_lo) begin
      next_count = {staging, WDATA};
    end else if (tick) begin
      next_count = free_running_count + 16'h0001;
    end else begin
      next_count = free_running_count;
    end
  end

  // ==========================================================
  // Capture channels
  wire [3:0] rd_cap_hi;
  wire [3:0] cap_block;
  wire [3:0] cap_strobe;
  wire [3:0] cap_sig;
  wire [3:0] buffered = {buffer_enable_b, buffer_enable_a, buffer_enable_b, buffer_enable_a};

  // Upper-byte address per capture register, channel a in the low nibble
  localparam [15:0] cap_hi_addr = {`FRCT_A_CAP_HI0 + 4'h6, `FRCT_A_CAP_HI0 + 4'h4,
                                   `FRCT_A_CAP_HI0 + 4'h2, `FRCT_A_CAP_HI0};
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_cap
      assign rd_cap_hi[gi] = RD & (ADDR == cap_hi_addr[4 * gi +: 4]);
    end
  endgenerate

  // buffer channel watches the primary input
  assign cap_sig[0] = CAPTURE_IN[0];
  assign cap_sig[1] = CAPTURE_IN[1];
  assign cap_sig[2] = buffer_enable_a ? CAPTURE_IN[0] : CAPTURE_IN[2];
  assign cap_sig[3] = buffer_enable_b ? CAPTURE_IN[1] : CAPTURE_IN[3];

  // buffered pair blocked by either read
  assign cap_block[0] = rd_cap_hi[0] | (buffer_enable_a & rd_cap_hi[2]);
  assign cap_block[1] = rd_cap_hi[1] | (buffer_enable_b & rd_cap_hi[3]);
  assign cap_block[2] = rd_cap_hi[2] | (buffer_enable_a & rd_cap_hi[0]);
  assign cap_block[3] = rd_cap_hi[3] | (buffer_enable_b & rd_cap_hi[1]);

  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_edge
      frct_edge u_edge (
        .clk       (CLK),
        .rst_n     (RST_N),
        .clr       (LOW_POWER),
        .sig       (cap_sig[gi]),
        .edge_rise (capture_edge[3 - gi]),
        .block     (cap_block[gi]),
        .strobe    (cap_strobe[gi])
      );
    end
  endgenerate

  // Primary loads on its own edge, or on the buffer edge when paired
  wire load_a = cap_strobe[0] | (buffer_enable_a & cap_strobe[2]);
  wire load_b = cap_strobe[1] | (buffer_enable_b & cap_strobe[3]);
  // paired buffer channel never loads the count itself
  wire [3:0] cap_load = {cap_strobe[3] & ~buffered[3], cap_strobe[2] & ~buffered[2], load_b, load_a};

  // ==========================================================
  // Capture registers
  integer ci;
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      for (ci = 0; ci < 4; ci = ci + 1) begin
        capture_reg[ci] <= `FRCT_CAP_RST;
      end
    end else if (LOW_POWER) begin
      for (ci = 0; ci < 4; ci = ci + 1) begin
        capture_reg[ci] <= `FRCT_CAP_RST;
      end
    end else begin
      for (ci = 0; ci < 2; ci = ci + 1) begin
        if (cap_load[ci]) begin
          capture_reg[ci] <= free_running_count;
        end
      end
      // buffered capture shifts old value down
      if (buffer_enable_a & load_a) begin
        capture_reg[2] <= capture_reg[0];
      end else if (cap_load[2]) begin
        capture_reg[2] <= free_running_count;
      end
      if (buffer_enable_b & load_b) begin
        capture_reg[3] <= capture_reg[1];
      end else if (cap_load[3]) begin
        capture_reg[3] <= free_running_count;
      end
    end
  end

  // ==========================================================
  // Counter, prescaler and compare registers
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      prescale           <= {PRESCALE_W{1'b0}};
      sel_prev           <= 1'b0;
      free_running_count <= `FRCT_CNT_RST;
      compare_reg_a      <= `FRCT_CMP_RST;
      compare_reg_b      <= `FRCT_CMP_RST;
    end else if (LOW_POWER) begin
      prescale           <= {PRESCALE_W{1'b0}};
      sel_prev           <= 1'b0;
      free_running_count <= `FRCT_CNT_RST;
      compare_reg_a      <= `FRCT_CMP_RST;
      compare_reg_b      <= `FRCT_CMP_RST;
    end else begin
      prescale           <= prescale + {{(PRESCALE_W-1){1'b0}}, 1'b1};
      sel_prev           <= sel_now;
      free_running_count <= next_count;
      // upper byte staged, lower byte commits
      if (wr_cmp_a) begin
        compare_reg_a <= {staging, WDATA};
      end
      if (wr_cmp_b) begin
        compare_reg_b <= {staging, WDATA};
      end
    end
  end

  // ==========================================================
  // Staging byte: write upper stages data, counter/capture read upper stages low half
  reg [7:0] next_staging;
  always @* begin
    next_staging = staging;
    if (WR && (ADDR == `FRCT_A_CNT_HI || ADDR == `FRCT_A_CMP_HI)) begin
      next_staging = WDATA;
    end else if (RD && ADDR == `FRCT_A_CNT_HI) begin
      next_staging = free_running_count[7:0];
    end else if (RD && ADDR >= `FRCT_A_CAP_HI0 && ADDR <= `FRCT_A_CAP_LO3 && !ADDR[0]) begin
      next_staging = capture_reg[ADDR[2:1] ^ 2'h2][7:0];
    end
  end

  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      staging <= 8'h00;
    end else if (LOW_POWER) begin
      staging <= 8'h00;
    end else begin
      staging <= next_staging;
    end
  end

  // ==========================================================
  // Control, flags and enables; a hardware set beats a software clear
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      timer_control_reg      <= `FRCT_CTRL_RST;
      compare_output_control <= `FRCT_OCTRL_RST;
      capture_flag           <= 4'h0;
      compare_flag_a         <= 1'b0;
      compare_flag_b         <= 1'b0;
      overflow_flag          <= 1'b0;
      clear_on_match_a       <= 1'b0;
      irq_enable_reg         <= 7'h00;
    end else if (LOW_POWER) begin
      timer_control_reg      <= `FRCT_CTRL_RST;
      compare_output_control <= `FRCT_OCTRL_RST;
      capture_flag           <= 4'h0;
      compare_flag_a         <= 1'b0;
      compare_flag_b         <= 1'b0;
      overflow_flag          <= 1'b0;
      clear_on_match_a       <= 1'b0;
      irq_enable_reg         <= 7'h00;
    end else begin
      if (wr_ctrl) begin
        timer_control_reg <= WDATA;
      end
      if (wr_octrl) begin
        compare_output_control <= WDATA[4:0];
      end
      if (wr_ien) begin
        irq_enable_reg <= WDATA[7:1];
      end
      if (wr_stat) begin
        clear_on_match_a <= WDATA[`FRCT_ST_CLR_A];
      end
      // flag sets with the register load
      capture_flag   <= cap_strobe | (capture_flag & ~({4{wr_stat}} & ~WDATA[7:4]));
      compare_flag_a <= match_a | (compare_flag_a & ~(wr_stat & ~WDATA[`FRCT_ST_CMP_A]));
      compare_flag_b <= match_b | (compare_flag_b & ~(wr_stat & ~WDATA[`FRCT_ST_CMP_B]));
      overflow_flag  <= ovf_set | (overflow_flag & ~(wr_stat & ~WDATA[`FRCT_ST_OVF]));
    end
  end

  // ==========================================================
  // Compare pins
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      COMPARE_OUT_A    <= 1'b0;
      COMPARE_OUT_B    <= 1'b0;
      COMPARE_OUT_A_OE <= 1'b0;
      COMPARE_OUT_B_OE <= 1'b0;
    end else if (LOW_POWER) begin
      COMPARE_OUT_A    <= 1'b0;
      COMPARE_OUT_B    <= 1'b0;
      COMPARE_OUT_A_OE <= 1'b0;
      COMPARE_OUT_B_OE <= 1'b0;
    end else begin
      if (match_a) begin
        COMPARE_OUT_A <= output_level_a;
      end
      if (match_b) begin
        COMPARE_OUT_B <= output_level_b;
      end
      COMPARE_OUT_A_OE <= wr_octrl ? WDATA[`FRCT_OC_OE_A] : compare_output_control[`FRCT_OC_OE_A];
      COMPARE_OUT_B_OE <= wr_octrl ? WDATA[`FRCT_OC_OE_B] : compare_output_control[`FRCT_OC_OE_B];
    end
  end

  // ==========================================================
  // Interrupt request
  // seven enabled sources, one request
  wire [6:0] irq_src = {capture_flag, compare_flag_a, compare_flag_b, overflow_flag};
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      IRQ <= 1'b0;
    end else if (LOW_POWER) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |(irq_src & irq_enable_reg);  // One cycle behind the flags
    end
  end

  // ==========================================================
  // Read data, valid only in the cycle after the read strobe
  reg [7:0] rd_mux;
  always @* begin
    case (ADDR)
      `FRCT_A_CNT_HI: rd_mux = free_running_count[15:8];
      `FRCT_A_CNT_LO: rd_mux = staging;
      `FRCT_A_CMP_HI: rd_mux = cmp_sel ? compare_reg_b[15:8] : compare_reg_a[15:8];
      `FRCT_A_CMP_LO: rd_mux = cmp_sel ? compare_reg_b[7:0] : compare_reg_a[7:0];
      `FRCT_A_CTRL:   rd_mux = timer_control_reg;
      `FRCT_A_OCTRL:  rd_mux = {`FRCT_OCTRL_RSV, compare_output_control};
      `FRCT_A_STAT:   rd_mux = {capture_flag, compare_flag_a, compare_flag_b, overflow_flag, clear_on_match_a};
      `FRCT_A_IEN:    rd_mux = {irq_enable_reg, 1'b0};
      // Capture registers: upper byte direct, lower byte from staging
      default:        rd_mux = ADDR[0] ? staging : capture_reg[ADDR[2:1] ^ 2'h2][15:8];
    endcase
  end

  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      RDATA <= 8'h00;
    end else begin
      RDATA <= RD ? rd_mux : 8'h00;
    end
  end
endmodule

// [frct_defines.vh]
// Register map, field positions and reset values of the capture/compare timer
// Function
// - Two select bits pick clock source
// - External source counts on rising edges
// - Compare match drives pin to level bit
// - Compare match A can clear counter
// - Per-channel edge bit picks rising/falling
// - Capture delayed during upper-byte read
// - Buffered opposite edges capture both edges
// - Buffer edge sets flag, loads pair via primary
// - Buffered capture delayed by either read
// - Capture flag sets with register load
// - Match strobe when counter leaves match
// - Overflow flag on wrap to zero
// - Low-power modes hold registers reset
// - Seven enabled sources, one shared request
// - Each interrupt follows its own flag
// - Clear beats lower-byte counter write
// - Lower-byte counter write beats increment
// - Compare register write suppresses match
// - Falling divided clock increments, switches too
// - Internal/external switch may increment once
// - Clear on match A only when enabled
// - Compare outputs zero after reset
// - Buffered capture shifts old value down
`ifndef FRCT_DEFINES_VH
`define FRCT_DEFINES_VH

// ==========================================================
// Byte addresses on the 8-bit register port
`define FRCT_A_CNT_HI  4'h0
`define FRCT_A_CNT_LO  4'h1
`define FRCT_A_CMP_HI  4'h2
`define FRCT_A_CMP_LO  4'h3
`define FRCT_A_CAP_HI0 4'h4
`define FRCT_A_CAP_LO3 4'hb
`define FRCT_A_CTRL    4'hc
`define FRCT_A_OCTRL   4'hd
`define FRCT_A_STAT    4'he
`define FRCT_A_IEN     4'hf

// ==========================================================
// Reset values
`define FRCT_CNT_RST   16'h0000
`define FRCT_CMP_RST   16'hffff
`define FRCT_CAP_RST   16'h0000
`define FRCT_CTRL_RST  8'h00
`define FRCT_OCTRL_RST 5'h00
`define FRCT_OCTRL_RSV 3'h7
`define FRCT_CNT_MAX   16'hffff

// ==========================================================
// Control register: edges [7:4] channel a..d, buffer enables, clock
`define FRCT_CTRL_EDGE_LO 4
`define FRCT_CTRL_BUF_A   3
`define FRCT_CTRL_BUF_B   2
`define FRCT_CKS_DIV2     2'h0
`define FRCT_CKS_DIV8     2'h1
`define FRCT_CKS_DIV32    2'h2
`define FRCT_CKS_EXT      2'h3

// Output control register fields
`define FRCT_OC_SEL   4
`define FRCT_OC_OE_A  3
`define FRCT_OC_OE_B  2
`define FRCT_OC_LVL_A 1
`define FRCT_OC_LVL_B 0

// Status register: capture flags [7:4], compare a, b, overflow, clear
`define FRCT_ST_CMP_A 3
`define FRCT_ST_CMP_B 2
`define FRCT_ST_OVF   1
`define FRCT_ST_CLR_A 0

// Prescaler taps for /2, /8 and /32
`define FRCT_TAP_DIV2  0
`define FRCT_TAP_DIV8  2
`define FRCT_TAP_DIV32 4

`endif

// [frct_edge.v]
// One capture channel: edge pick and one-clock postponement
`timescale 1ns/1ps
module frct_edge (
  input  wire clk,
  input  wire rst_n,
  input  wire clr,
  input  wire sig,
  input  wire edge_rise,
  input  wire block,
  output wire strobe
);
  reg  prev;
  reg  pend;
  wire hit;

  // ==========================================================
  // Edge detection
  // chosen edge only
  assign hit = edge_rise ? (sig & ~prev) : (~sig & prev);

  assign strobe = pend | (hit & ~block);

  // Input history and pending capture
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev <= 1'b0;
      pend <= 1'b0;
    end else if (clr) begin
      prev <= 1'b0;
      pend <= 1'b0;
    end else begin
      prev <= sig;
      pend <= hit & block;  // Read in progress, retry next clock
    end
  end
endmodule

// [frct_timer_assertions.sv]
// Port-level assertions for the capture/compare timer
`timescale 1ns/1ps
module frct_checker (
  input wire       CLK,
  input wire       RST_N,
  input wire [3:0] ADDR,
  input wire [7:0] WDATA,
  input wire       WR,
  input wire       RD,
  input wire [7:0] RDATA,
  input wire       LOW_POWER,
  input wire       COMPARE_OUT_A,
  input wire       COMPARE_OUT_A_OE,
  input wire       COMPARE_OUT_B,
  input wire       COMPARE_OUT_B_OE,
  input wire       IRQ
);
  reg [3:0] oct;
  reg [7:1] ien;

  // ====================
  // Shadows of output control and irq enables
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      oct <= 4'h0;
      ien <= 7'h00;
    end else if (LOW_POWER) begin
      oct <= 4'h0;
      ien <= 7'h00;
    end else if (WR && ADDR == 4'hd) begin
      oct <= WDATA[3:0];
    end else if (WR && ADDR == 4'hf) begin
      ien <= WDATA[7:1];
    end
  end

  // ====================
  // Properties on the single clock
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  sequence s_no_read;
    !RD;
  endsequence
  // Low power also resets the pin, so that change is not a match
  sequence s_pin_a_moves;
    $changed(COMPARE_OUT_A) && !$past(LOW_POWER);
  endsequence

  a_reset_quiet: assert property ($rose(RST_N) |->
    !(COMPARE_OUT_A || COMPARE_OUT_A_OE || COMPARE_OUT_B || COMPARE_OUT_B_OE || IRQ))
    else $error("Outputs not idle after reset");
  a_lowpower_quiet: assert property (LOW_POWER |=>
    !(COMPARE_OUT_A || COMPARE_OUT_A_OE || COMPARE_OUT_B || COMPARE_OUT_B_OE || IRQ))
    else $error("Outputs not cleared in low power");
  a_pin_level_a: assert property (s_pin_a_moves |-> COMPARE_OUT_A == $past(oct[1]))
    else $error("Pin A moved to wrong level");
  a_pin_level_b: assert property ($changed(COMPARE_OUT_B) && !$past(LOW_POWER) |->
    COMPARE_OUT_B == $past(oct[0]))
    else $error("Pin B moved to wrong level");
  a_oe_follow_a: assert property ($stable(oct) |-> COMPARE_OUT_A_OE == oct[3])
    else $error("Pin A enable wrong");
  a_oe_follow_b: assert property ($stable(oct[2]) |-> COMPARE_OUT_B_OE == oct[2])
    else $error("Pin B enable wrong");
  a_irq_gated: assert property ((ien == 7'h00) [*2] |-> !IRQ)
    else $error("Request with all enables off");
  a_rdata_idle: assert property (s_no_read |=> RDATA == 8'h00)
    else $error("Read data outside read cycle");
endmodule

bind frct_timer frct_checker i_frct_checker (
  .CLK, .RST_N, .ADDR, .WDATA, .WR, .RD, .RDATA, .LOW_POWER,
  .COMPARE_OUT_A, .COMPARE_OUT_A_OE, .COMPARE_OUT_B, .COMPARE_OUT_B_OE, .IRQ
);

// [frct_partner.sv]
// Far-side model: count clock source, capture sources, pin A load
`timescale 1ns/1ps
module frct_partner (
  input  wire       clk,
  input  wire       pin_a,
  input  wire       oe_a,
  output reg        ext_clk,
  output reg  [3:0] cap_in,
  output wire       line_a
);
  // Pull-down: an undriven pin reads low
  assign line_a = oe_a ? pin_a : 1'b0;

  initial begin
    ext_clk = 1'b0;
    cap_in = 4'h0;
  end

  task pulses(input integer n);
    integer j;
    begin
      for (j = 0; j < n; j = j + 1) begin
        @(posedge clk);
        ext_clk <= 1'b1;
        repeat (2) @(posedge clk);
        ext_clk <= 1'b0;
        repeat (2) @(posedge clk);
      end
    end
  endtask

  // Level held long enough for edge detect and strobe
  task set_cap(input [3:0] v);
    begin
      @(posedge clk);
      cap_in <= v;
      repeat (4) @(posedge clk);
    end
  endtask
endmodule

// [test_free_running_capture_compare_timer.sv]
// Self-checking bench for the capture/compare timer
`timescale 1ns/1ps
module test_free_running_capture_compare_timer;
  // Rows: address, write byte, expected read byte
  localparam logic [19:0] ROWS [0:5] = '{20'hd_1f_ff, 20'hd_02_e2, 20'hf_ff_fe,
                                         20'hf_00_00, 20'hc_f1_f1, 20'hc_03_03};
  reg         clk;
  reg         rst_n;
  reg  [3:0]  addr;
  reg  [7:0]  wdata;
  reg         wr;
  reg         rd;
  reg         low_power;
  reg  [15:0] got;
  wire [7:0]  rdata;
  wire [3:0]  cap_in;
  wire        ext_clk;
  wire        a_out;
  wire        a_oe;
  wire        b_out;
  wire        b_oe;
  wire        irq;
  wire        line_a;
  integer     n_fail;
  integer     cmp_count;
  integer     i;
  integer     k;
  integer     e;

  frct_timer #(.PRESCALE_W(5)) i_frct_timer (
    .CLK(clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .LOW_POWER(low_power), .EXT_CLK(ext_clk), .CAPTURE_IN(cap_in),
    .COMPARE_OUT_A(a_out), .COMPARE_OUT_A_OE(a_oe), .COMPARE_OUT_B(b_out),
    .COMPARE_OUT_B_OE(b_oe), .IRQ(irq));
  frct_partner i_frct_partner (.clk(clk), .pin_a(a_out), .oe_a(a_oe),
    .ext_clk(ext_clk), .cap_in(cap_in), .line_a(line_a));

  always #5 clk = ~clk;

  // ====================
  // Checking, bus and reset-value tasks
  task chk(input [15:0] seen, input [15:0] exp, input [95:0] what);
    begin
      cmp_count = cmp_count + 1;
      if (seen !== exp) begin
        n_fail = n_fail + 1;
        $display("Error %0s expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  task bus_wr(input [3:0] a, input [7:0] d);
    begin
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
    end
  endtask
  // Shifts the byte in, so two reads build a 16-bit value
  task bus_rd(input [3:0] a);
    begin
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1 got = {got[7:0], rdata};
    end
  endtask
  task wr16(input [3:0] a, input [15:0] v);
    begin
      bus_wr(a, v[15:8]);
      bus_wr(a + 4'h1, v[7:0]);
    end
  endtask
  task rd16(input [3:0] a);
    begin
      bus_rd(a);
      bus_rd(a + 4'h1);
    end
  endtask
  task chk_rst;
    begin
      bus_rd(4'hd);
      chk(got & 16'h00ff, 16'h00e0, "out ctrl");
      rd16(4'h2);
      chk(got, 16'hffff, "compare");
      rd16(4'h4);
      chk(got, 16'h0000, "capture");
      chk({11'h000, a_out, a_oe, b_out, b_oe, irq}, 16'h0000, "pins");
    end
  endtask
  task complete_run;
    begin
      if (n_fail == 0 && cmp_count > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask

  // ====================
  // Main sequence
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    addr = 4'h0;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    low_power = 1'b0;
    got = 16'h0000;
    n_fail = 0;
    cmp_count = 0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    chk_rst;
    for (i = 0; i < 6; i = i + 1) begin
      bus_wr(ROWS[i][19:16], ROWS[i][15:8]);
      bus_rd(ROWS[i][19:16]);
      chk(got & 16'h00ff, {8'h00, ROWS[i][7:0]}, "register");
    end
    // Internal rates over 66 cycles, one count of slack for phase
    for (i = 0; i < 3; i = i + 1) begin
      bus_wr(4'hc, i[7:0]);
      wr16(4'h0, 16'h0000);
      repeat (64) @(posedge clk);
      rd16(4'h0);
      e = 66 >> (2 * i + 1);
      chk((got + 1 >= e && got <= e + 1) ? 16'h1 : 16'h0, 16'h1, "rate");
    end
    bus_wr(4'hc, 8'h03);
    wr16(4'h0, 16'h0000);
    i_frct_partner.pulses(5);
    rd16(4'h0);
    chk(got, 16'h0005, "ext count");
    // Compare A at 5 with clear, pin high, irq on
    bus_wr(4'hd, 8'h0a);
    #1 chk({14'h0000, a_oe, b_oe}, 16'h0002, "enables");
    wr16(4'h2, 16'h0005);
    bus_wr(4'hf, 8'h08);
    bus_wr(4'he, 8'h01);
    wr16(4'h0, 16'h0000);
    i_frct_partner.pulses(5);
    bus_rd(4'he);
    chk(got & 16'h00ff, 16'h0001, "early flag");
    chk({15'h0000, line_a}, 16'h0000, "early pin");
    i_frct_partner.pulses(1);
    bus_rd(4'he);
    chk(got & 16'h00ff, 16'h0009, "match flag");
    chk({14'h0000, line_a, irq}, 16'h0003, "pin irq");
    rd16(4'h0);
    chk(got, 16'h0000, "cleared");
    bus_wr(4'hf, 8'h00);
    repeat (2) @(posedge clk);
    #1 chk({15'h0000, irq}, 16'h0000, "masked");
    bus_wr(4'he, 8'h00);
    wr16(4'h0, 16'h0000);
    i_frct_partner.pulses(6);
    rd16(4'h0);
    chk(got, 16'h0006, "no clear");
    bus_wr(4'hd, 8'h00);
    #1 chk({15'h0000, line_a}, 16'h0000, "pin released");
    bus_wr(4'he, 8'h00);
    wr16(4'h0, 16'hffff);
    i_frct_partner.pulses(1);
    bus_rd(4'he);
    chk(got & 16'h00ff, 16'h0006, "overflow");
    // Rising then falling selection; only the chosen edge loads
    for (i = 0; i < 2; i = i + 1) begin
      bus_wr(4'hc, i ? 8'h03 : 8'hf3);
      bus_wr(4'he, 8'h00);
      wr16(4'h0, 16'h1234 + i[15:0]);
      i_frct_partner.set_cap(4'hf);
      wr16(4'h0, 16'h5678 + i[15:0]);
      i_frct_partner.set_cap(4'h0);
      for (k = 0; k < 4; k = k + 1) begin
        rd16(4'h4 + {k[2:0], 1'b0});
        chk(got, i ? 16'h5679 : 16'h1234, "capture");
      end
      bus_rd(4'he);
      chk(got & 16'h00f0, 16'h00f0, "cap flags");
    end
    // Buffered pairs, primary falling and buffer rising; values read back from pair A only
    bus_wr(4'hc, 8'h3f);
    bus_wr(4'he, 8'h00);
    wr16(4'h0, 16'h1111);
    i_frct_partner.set_cap(4'hf);
    wr16(4'h0, 16'h2222);
    i_frct_partner.set_cap(4'h0);
    rd16(4'h4);
    chk(got, 16'h2222, "primary");
    rd16(4'h8);
    chk(got, 16'h1111, "buffer");
    bus_rd(4'he);
    chk(got & 16'h00f0, 16'h00f0, "buf flags");
    @(posedge clk);
    low_power <= 1'b1;
    repeat (2) @(posedge clk);
    low_power <= 1'b0;
    chk_rst;
    complete_run;
  end

  // Watchdog well beyond the roughly 550 cycles needed
  initial begin
    #100000;
    n_fail = n_fail + 1;
    complete_run;
  end
endmodule
